// ==== verilog/pwm_out_defines.svh ====
/*
  constants for the four-pair pwm compare, dead-time and output stage:
  register word offsets, field positions, widths and encodings.
  assumes it is included by bare name from the package and the design.
*/
`ifndef PWM_OUT_DEFINES_SVH
`define PWM_OUT_DEFINES_SVH

// widths
`define PWM_PAIRS 4
`define PWM_DUTY_W 16
`define PWM_TB_W 15
`define PWM_DT_W 6
`define PWM_PS_W 3
`define PWM_ADDR_W 4

// register word offsets
`define PWM_ADR_DUTY1 4'h0
`define PWM_ADR_DUTY2 4'h1
`define PWM_ADR_DUTY3 4'h2
`define PWM_ADR_DUTY4 4'h3
`define PWM_ADR_PIN_CTL 4'h4
`define PWM_ADR_UPD_CTL 4'h5
`define PWM_ADR_DT_CFG 4'h6
`define PWM_ADR_DT_ASN 4'h7
`define PWM_ADR_OVR 4'h8
`define PWM_ADR_STATUS 4'h9

// update control fields
`define PWM_UPD_LOCK_BIT 0
`define PWM_UPD_IMM_BIT 1

// dead time config fields
`define PWM_DTA_CNT 5:0
`define PWM_DTA_PS 7:6
`define PWM_DTB_CNT 13:8
`define PWM_DTB_PS 15:14

// override register: low byte selects, high byte levels
`define PWM_OVR_SEL 7:0
`define PWM_OVR_LVL 15:8

// time base mode codes
`define PWM_TB_FREE 2'h0
`define PWM_TB_SINGLE 2'h1
`define PWM_TB_UPDOWN 2'h2
`define PWM_TB_DOUBLE 2'h3
`define PWM_TB_CENTER_BIT 1

// misc constants
`define PWM_DUTY_ZERO 16'h0000
`define PWM_DT_ZERO 6'h00
`define PWM_DT_ONE 6'h01
`define PWM_PS_ZERO 3'h0
`define PWM_PS_ONE 3'h1
`define PWM_PS_BASE 3'h1
`define PWM_RD_ZERO 16'h0000

`endif

// ==== verilog/pwm_out_pkg.sv ====
/*
  types for the pwm output stage: the packed state record of the block.
  assumes pwm_out_defines.svh is on the include path.
*/
`include "pwm_out_defines.svh"

package pwm_out_pkg;

  // whole register state of the block, one record
  typedef struct packed {
    logic [`PWM_PAIRS-1:0][`PWM_DUTY_W-1:0] duty_buf; // software side
    logic [`PWM_PAIRS-1:0][`PWM_DUTY_W-1:0] duty_act; // compare side
    logic [`PWM_PAIRS-1:0] indep; // pair_independent_select
    logic update_lockout; // blocks buffered loads
    logic immediate_update; // writes go straight to compare
    logic [`PWM_DUTY_W-1:0] dt_cfg; // dead_time_config
    logic [2*`PWM_PAIRS-1:0] dt_asn; // dead_time_assign
    logic [`PWM_DUTY_W-1:0] ovr; // output_override_control
    logic [`PWM_PAIRS-1:0] cmp; // compare output levels
    logic [`PWM_PAIRS-1:0][`PWM_DT_W-1:0] dt_cnt; // dead-time down counters
    logic [`PWM_PAIRS-1:0] dt_unit; // unit in use per pair
    logic [`PWM_PAIRS-1:0][`PWM_PS_W-1:0] ps_cnt; // dead-time prescalers
    logic [`PWM_PAIRS-1:0] hi; // high pins
    logic [`PWM_PAIRS-1:0] lo; // low pins
    logic [`PWM_DUTY_W-1:0] rdata; // read data
  } pwm_state_t;

endpackage

// ==== verilog/pwm_duty_deadtime_outputs.sv ====
/*
  four-pair pwm compare, double-buffered duty, dead-time and pin stage.
  assumes the time base (count, direction, period, run, mode) comes from
  logic on the same clock, and a one-cycle register strobe port.
*/
// The strobed register port and the address map were chosen for this implementation.
// What this block does
// R1: down count match drives compare active
// R2: up count match drives compare inactive
// R3: center duty zero keeps output inactive
// R4: center duty equal period keeps active
// R5: four 16-bit duty registers
// R6: duty lsb gives half-step edge placement; the code rounds an odd duty up to the next whole count instead
// R7: buffer plus active compare per channel
// R8: edge mode loads at period match
// R9: edge mode stopped loads continuously
// R10: single up/down loads at zero, stopped
// R11: double mode loads at zero and period
// R12: immediate update applies writes at once
// R13: immediate write lengthens, shortens or activates
// R14: duty n drives pair n, low complements
// R15: pairs complementary when clear, reset default
// R16: two dead times, split by edge
// R17: 6-bit down counter per pair, edge triggered
// R18: per pair active and inactive selects
// R19: 2-bit prescale and 6-bit count each
// R20: prescalers cleared on load, reset, and on write for pairs not counting dead time
// R21: software keeps dead-time settings while running
// R22: independent pair drives both, no dead time
// R23: lockout blocks buffered loads, not immediate
// R24: direction flag zero up, one down
// R25: override selects software level per pin
// R26: counter holds turning-on pin inactive
`include "pwm_out_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module pwm_duty_deadtime_outputs (
  input wire logic clk, // 100 MHz instruction clock
  input wire logic rst, // synchronous, active high
  input wire logic [`PWM_ADDR_W-1:0] addr, // register word offset
  input wire logic [`PWM_DUTY_W-1:0] wr_data, // write data
  input wire logic wr_stb, // one-cycle write strobe
  input wire logic rd_stb, // one-cycle read strobe
  output logic [`PWM_DUTY_W-1:0] rd_data, // read data, cycle after strobe
  input wire logic [`PWM_TB_W-1:0] time_base_count, // shared count
  input wire logic count_down_flag, // 1 while counting down
  input wire logic [`PWM_TB_W-1:0] period_value, // active period
  input wire logic time_base_run, // time base enabled
  input wire logic [1:0] time_base_mode, // free, single, up/down, double
  output logic pair1_high_out, // pair 1 high pin
  output logic pair1_low_out, // pair 1 low pin
  output logic pair2_high_out, // pair 2 high pin
  output logic pair2_low_out, // pair 2 low pin
  output logic pair3_high_out, // pair 3 high pin
  output logic pair3_low_out, // pair 3 low pin
  output logic pair4_high_out, // pair 4 high pin
  output logic pair4_low_out // pair 4 low pin
);

  // edge match value on the count scale; lsb rounds up, so an odd duty
  // reaches the downward match one count earlier and widens the pulse
  function automatic logic [`PWM_DUTY_W-1:0] match_val(
    input logic [`PWM_DUTY_W-1:0] d
  );
    match_val = {1'b0, d[`PWM_DUTY_W-1:1]} + {{(`PWM_DUTY_W-1){1'b0}}, d[0]};
  endfunction

  // last prescaler value before a tick: 1, 2, 4 or 8 cycles per count
  function automatic logic [`PWM_PS_W-1:0] ps_last(input logic [1:0] code);
    ps_last = (`PWM_PS_BASE << code) - `PWM_PS_ONE;
  endfunction

  pwm_out_pkg::pwm_state_t r_r; // registered state
  pwm_out_pkg::pwm_state_t s_nxt; // next state

  logic [`PWM_DUTY_W-1:0] count_w; // count widened to duty width
  logic per_match; // count equals period
  logic cnt_zero; // count is zero
  logic center; // up/down family
  logic load_evt; // period boundary load instant
  logic [`PWM_PAIRS-1:0] imm_wr; // immediate write per channel
  logic [`PWM_DUTY_W-1:0] m; // current match value
  logic c; // new compare level
  logic rise; // compare rising edge
  logic fall; // compare falling edge
  logic unit; // dead-time unit chosen at an edge
  logic [1:0] ps_code; // prescale code of the running unit

  assign count_w = {1'b0, time_base_count};
  assign per_match = (time_base_count == period_value);
  assign cnt_zero = (time_base_count == {`PWM_TB_W{1'b0}});
  assign center = time_base_mode[`PWM_TB_CENTER_BIT];

  // next-state logic: bus, loads, compare, dead time, pins
  always_comb begin
    s_nxt = r_r;
    s_nxt.rdata = `PWM_RD_ZERO;
    imm_wr = '0;
    m = `PWM_DUTY_ZERO;
    c = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    unit = 1'b0;
    ps_code = 2'h0;
    load_evt = 1'b0;

    // pick the buffered load instant for the running mode
    unique case (time_base_mode)
      // R8: edge mode period match
      `PWM_TB_FREE, `PWM_TB_SINGLE: begin
        load_evt = time_base_run & per_match;
      end
      // R10: zero while turning upward
      `PWM_TB_UPDOWN: begin
        load_evt = time_base_run & cnt_zero & ~count_down_flag;
      end
      // R11: zero and period match
      `PWM_TB_DOUBLE: begin
        load_evt = time_base_run & (cnt_zero | per_match);
      end
    endcase
    // R9: stopped base loads continuously
    if (!time_base_run) begin
      load_evt = 1'b1;
    end

    // R23: lockout blocks buffered loads
    if (load_evt && !r_r.update_lockout) begin
      // R7: buffer copied to compare side
      s_nxt.duty_act = r_r.duty_buf;
    end

    // register writes; an immediate write lands after the buffered load
    if (wr_stb) begin
      unique case (addr)
        // R5: four duty registers
        `PWM_ADR_DUTY1, `PWM_ADR_DUTY2, `PWM_ADR_DUTY3, `PWM_ADR_DUTY4: begin
          s_nxt.duty_buf[addr[1:0]] = wr_data;
          // R12: immediate update bypasses buffer
          if (r_r.immediate_update) begin
            s_nxt.duty_act[addr[1:0]] = wr_data;
            imm_wr[addr[1:0]] = 1'b1;
          end
        end
        `PWM_ADR_PIN_CTL: begin
          s_nxt.indep = wr_data[`PWM_PAIRS-1:0];
        end
        `PWM_ADR_UPD_CTL: begin
          s_nxt.update_lockout = wr_data[`PWM_UPD_LOCK_BIT];
          s_nxt.immediate_update = wr_data[`PWM_UPD_IMM_BIT];
        end
        // R20: config write clears prescalers of pairs not counting dead time
        `PWM_ADR_DT_CFG: begin
          s_nxt.dt_cfg = wr_data;
          s_nxt.ps_cnt = '0;
        end
        `PWM_ADR_DT_ASN: begin
          s_nxt.dt_asn = wr_data[2*`PWM_PAIRS-1:0];
          s_nxt.ps_cnt = '0;
        end
        `PWM_ADR_OVR: begin
          s_nxt.ovr = wr_data;
        end
        // status and unmapped offsets ignore writes
        default: begin
        end
      endcase
    end

    // reads answer next cycle; unmapped offsets read zero
    if (rd_stb) begin
      unique case (addr)
        `PWM_ADR_DUTY1, `PWM_ADR_DUTY2, `PWM_ADR_DUTY3, `PWM_ADR_DUTY4: begin
          s_nxt.rdata = r_r.duty_buf[addr[1:0]];
        end
        `PWM_ADR_PIN_CTL: begin
          s_nxt.rdata[`PWM_PAIRS-1:0] = r_r.indep;
        end
        `PWM_ADR_UPD_CTL: begin
          s_nxt.rdata[`PWM_UPD_LOCK_BIT] = r_r.update_lockout;
          s_nxt.rdata[`PWM_UPD_IMM_BIT] = r_r.immediate_update;
        end
        `PWM_ADR_DT_CFG: begin
          s_nxt.rdata = r_r.dt_cfg;
        end
        `PWM_ADR_DT_ASN: begin
          s_nxt.rdata[2*`PWM_PAIRS-1:0] = r_r.dt_asn;
        end
        `PWM_ADR_OVR: begin
          s_nxt.rdata = r_r.ovr;
        end
        // compare levels in the low nibble, direction above them
        `PWM_ADR_STATUS: begin
          s_nxt.rdata[`PWM_PAIRS-1:0] = r_r.cmp;
          // R24: direction flag readback
          s_nxt.rdata[`PWM_PAIRS] = count_down_flag;
        end
        default: begin
          s_nxt.rdata = `PWM_RD_ZERO;
        end
      endcase
    end

    // per channel compare and dead time
    for (int i = 0; i < `PWM_PAIRS; i++) begin
      // R6: odd duty lsb rounds the match up a whole count
      m = match_val(s_nxt.duty_act[i]);
      c = r_r.cmp[i];
      if (!center) begin
        // edge aligned: active from zero until the match
        c = (count_w < m);
      end else if (s_nxt.duty_act[i] == `PWM_DUTY_ZERO) begin
        // R3: zero duty never active
        c = 1'b0;
      end else if (s_nxt.duty_act[i][`PWM_DUTY_W-1:1] >= {1'b0, period_value}) begin
        // R4: duty at period always active
        c = 1'b1;
      end else if (count_down_flag && count_w == m) begin
        // R1: downward match turns on
        c = 1'b1;
      end else if (!count_down_flag && count_w == m) begin
        // R2: upward match turns off
        c = 1'b0;
      end
      // R13: immediate write reaching beyond count
      if (center && imm_wr[i] && !r_r.cmp[i] && m > count_w) begin
        c = 1'b1;
      end
      s_nxt.cmp[i] = c;

      // R17: edge detectors on compare output
      rise = c & ~r_r.cmp[i];
      fall = ~c & r_r.cmp[i];
      ps_code = r_r.dt_unit[i] ? r_r.dt_cfg[`PWM_DTB_PS] : r_r.dt_cfg[`PWM_DTA_PS];

      if (r_r.indep[i]) begin
        // R22: independent pair, no dead time
        s_nxt.hi[i] = c;
        s_nxt.lo[i] = c;
        s_nxt.dt_cnt[i] = `PWM_DT_ZERO;
      end else if (rise || fall) begin
        // R18: active or inactive edge select
        unit = rise ? r_r.dt_asn[2*i] : r_r.dt_asn[2*i+1];
        s_nxt.dt_unit[i] = unit;
        // R16: unit count loaded per edge
        s_nxt.dt_cnt[i] = unit ? r_r.dt_cfg[`PWM_DTB_CNT] : r_r.dt_cfg[`PWM_DTA_CNT];
        // R20: load clears this prescaler
        s_nxt.ps_cnt[i] = `PWM_PS_ZERO;
        // the side turning off drops at once; the other waits
        s_nxt.hi[i] = rise && (s_nxt.dt_cnt[i] == `PWM_DT_ZERO);
        s_nxt.lo[i] = fall && (s_nxt.dt_cnt[i] == `PWM_DT_ZERO);
      end else if (r_r.dt_cnt[i] != `PWM_DT_ZERO) begin
        // R26: both held off while counting
        s_nxt.hi[i] = 1'b0;
        s_nxt.lo[i] = 1'b0;
        // R19: prescaled count rate
        if (r_r.ps_cnt[i] >= ps_last(ps_code)) begin
          s_nxt.ps_cnt[i] = `PWM_PS_ZERO;
          s_nxt.dt_cnt[i] = r_r.dt_cnt[i] - `PWM_DT_ONE;
          // last tick releases the waiting pin, so a count of k waits k ticks
          if (r_r.dt_cnt[i] == `PWM_DT_ONE) begin
            s_nxt.hi[i] = c;
            s_nxt.lo[i] = ~c;
          end
        end else begin
          s_nxt.ps_cnt[i] = r_r.ps_cnt[i] + `PWM_PS_ONE;
        end
      end else begin
        // R14: low pin complements high pin
        s_nxt.hi[i] = c;
        s_nxt.lo[i] = ~c;
      end

      // R25: per-pin software override
      if (r_r.ovr[2*i]) begin
        s_nxt.hi[i] = r_r.ovr[`PWM_DUTY_W/2+2*i];
      end
      if (r_r.ovr[2*i+1]) begin
        s_nxt.lo[i] = r_r.ovr[`PWM_DUTY_W/2+2*i+1];
      end
    end
  end

  // state register; reset leaves every pair complementary and pins low
  always_ff @(posedge clk) begin
    if (rst) begin
      // R15: complementary default after reset
      r_r <= '0;
    end else begin
      r_r <= s_nxt;
    end
  end

  // pins and read data come straight from the state record
  assign rd_data = r_r.rdata;
  assign pair1_high_out = r_r.hi[0];
  assign pair1_low_out = r_r.lo[0];
  assign pair2_high_out = r_r.hi[1];
  assign pair2_low_out = r_r.lo[1];
  assign pair3_high_out = r_r.hi[2];
  assign pair3_low_out = r_r.lo[2];
  assign pair4_high_out = r_r.hi[3];
  assign pair4_low_out = r_r.lo[3];

endmodule

`default_nettype wire

// ==== tb/pwm_out_checker_sva.sv ====
/*
  port-level checker for the pwm output stage, bound to its top module.
  assumes the register map and the two-cycle pin lag of the design.
*/
`timescale 1ns/100ps
`default_nettype none

module pwm_out_checker (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic [3:0] addr, // offset
  input wire logic [15:0] wr_data, // write data
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  input wire logic [15:0] rd_data, // read data
  input wire logic pair1_high_out, // pin
  input wire logic pair1_low_out, // pin
  input wire logic pair2_high_out, // pin
  input wire logic pair2_low_out, // pin
  input wire logic pair3_high_out, // pin
  input wire logic pair3_low_out, // pin
  input wire logic pair4_high_out, // pin
  input wire logic pair4_low_out // pin
);
  logic [3:0][15:0] duty_r; // shadow duty buffers
  logic [3:0] indep_r; // shadow pair modes
  logic [15:0] dt_r; // shadow dead time
  logic [15:0] ovr_r; // shadow override
  logic [15:0] exp_r; // expected readback
  logic rdv_r; // duty read answered now
  logic [3:0] hi; // high pins
  logic [3:0] lo; // low pins
  logic [7:0] pins; // bit 2(n-1) is high pin n
  logic [3:0] ovr_pair; // pair has an override
  logic dt_ok; // pair 1 waits two or more
  assign hi = {pair4_high_out, pair3_high_out, pair2_high_out, pair1_high_out};
  assign lo = {pair4_low_out, pair3_low_out, pair2_low_out, pair1_low_out};
  assign pins = {lo[3], hi[3], lo[2], hi[2], lo[1], hi[1], lo[0], hi[0]};
  assign ovr_pair = {|ovr_r[7:6], |ovr_r[5:4], |ovr_r[3:2], |ovr_r[1:0]};
  // both counts two or more, so the far pin must stay off a cycle
  assign dt_ok = !indep_r[0] && !ovr_pair[0] && dt_r[5:1] != 5'h00 && dt_r[13:9] != 5'h00;
  // shadow software writes, since modes are not visible at the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      duty_r <= '0;
      indep_r <= 4'h0;
      dt_r <= 16'h0000;
      ovr_r <= 16'h0000;
      rdv_r <= 1'b0;
    end else begin
      if (wr_stb && addr < 4'h4)
        duty_r[addr[1:0]] <= wr_data;
      if (wr_stb && addr == 4'h4)
        indep_r <= wr_data[3:0];
      if (wr_stb && addr == 4'h6)
        dt_r <= wr_data;
      if (wr_stb && addr == 4'h8)
        ovr_r <= wr_data;
      rdv_r <= rd_stb && addr < 4'h4;
    end
    exp_r <= duty_r[addr[1:0]];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RD_IDLE: assert property (!$past(rd_stb) |-> rd_data == 16'h0000)
    else $error("read data not idle");
  AST_RD_UNMAPPED: assert property (rd_stb && addr >= 4'ha |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  AST_RESET_PINS: assert property ($past(rst) |-> pins == 8'h00)
    else $error("pins active after reset");
  AST_RD_DUTY: assert property (rdv_r |-> rd_data == exp_r)
    else $error("duty readback differs");
  AST_NO_SHOOT: assert property (indep_r == $past(indep_r, 3) && ovr_r == $past(ovr_r, 3)
    |-> (hi & lo & ~indep_r & ~ovr_pair) == 4'h0)
    else $error("both pins of a pair on");
  AST_INDEP_BOTH: assert property (indep_r == $past(indep_r, 3) && ovr_r == $past(ovr_r, 3)
    |-> ((hi ^ lo) & indep_r & ~ovr_pair) == 4'h0)
    else $error("independent pins differ");
  AST_OVR_LEVEL: assert property (ovr_r == $past(ovr_r, 2)
    |-> ((pins ^ ovr_r[15:8]) & ovr_r[7:0]) == 8'h00)
    else $error("override level not shown");
  AST_DEAD_ON: assert property (dt_ok && $fell(pair1_low_out) |=> !pair1_high_out)
    else $error("high side on without dead time");
  AST_DEAD_OFF: assert property (dt_ok && $fell(pair1_high_out) |=> !pair1_low_out)
    else $error("low side on without dead time");

  cover property (dt_ok && $rose(pair1_high_out));
  cover property (rdv_r);
  cover property (|(hi & lo & indep_r));
endmodule

bind pwm_duty_deadtime_outputs pwm_out_checker chk (.clk(clk), .rst(rst), .addr(addr),
  .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .pair1_high_out(pair1_high_out), .pair1_low_out(pair1_low_out),
  .pair2_high_out(pair2_high_out), .pair2_low_out(pair2_low_out),
  .pair3_high_out(pair3_high_out), .pair3_low_out(pair3_low_out),
  .pair4_high_out(pair4_high_out), .pair4_low_out(pair4_low_out));
`default_nettype wire

// ==== tb/half_bridge_model.sv ====
/*
  four half-bridge gate drivers on the pin pairs.
  assumes active-high gates sampled on the bench clock.
*/
`timescale 1ns/100ps
`default_nettype none

module half_bridge_model (
  input wire logic clk, // bench clock
  input wire logic [3:0] gate_hi, // high gates
  input wire logic [3:0] gate_lo, // low gates
  output logic [3:0] phase, // bridge node
  output logic [7:0] shoot_cnt // cycles both on
);
  initial phase = 4'h0;
  initial shoot_cnt = 8'h00;
  // a node with both switches off floats: show a moving level, not a stale one
  always @(posedge clk) begin
    phase <= (gate_hi & ~gate_lo) | (~phase & ~gate_hi & ~gate_lo);
    shoot_cnt <= shoot_cnt + {7'h00, |(gate_hi & gate_lo)};
  end
endmodule
`default_nettype wire

// ==== tb/pwm_duty_deadtime_outputs_test.sv ====
/*
  bench for the pwm output stage: register tasks, a time base stand-in
  and directed tests. assumes the design's one-cycle strobe port.
*/
`timescale 1ns/100ps
`default_nettype none

module pwm_duty_deadtime_outputs_test;
  logic clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, run = 1'b0, dn = 1'b0;
  logic [3:0] addr = 4'h0, e;
  logic [15:0] wr_data = 16'h0000, rd_data;
  logic [14:0] cnt = 15'h0000, per = 15'h0009;
  logic [1:0] mode = 2'h0;
  logic [3:0] phase;
  logic [7:0] shoot;
  wire [3:0] hi, lo;
  int num_errors = 0, checks_done = 0;

  pwm_duty_deadtime_outputs dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .time_base_count(cnt),
    .count_down_flag(dn), .period_value(per), .time_base_run(run), .time_base_mode(mode),
    .pair1_high_out(hi[0]), .pair1_low_out(lo[0]), .pair2_high_out(hi[1]),
    .pair2_low_out(lo[1]), .pair3_high_out(hi[2]), .pair3_low_out(lo[2]),
    .pair4_high_out(hi[3]), .pair4_low_out(lo[3]));
  half_bridge_model fet (.clk(clk), .gate_hi(hi), .gate_lo(lo), .phase(phase),
    .shoot_cnt(shoot));

  initial forever #5 clk = ~clk;
  // time base stand-in: edge modes wrap, center modes turn round
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 15'h0000;
      dn <= 1'b0;
    end else if (!mode[1]) begin
      dn <= 1'b0;
      cnt <= (cnt == per) ? 15'h0000 : cnt + 15'h0001;
      if (cnt == per && mode == 2'h1)
        run <= 1'b0;
    end else if (!dn) begin
      dn <= (cnt == per);
      cnt <= (cnt == per) ? cnt - 15'h0001 : cnt + 15'h0001;
    end else begin
      dn <= (cnt != 15'h0001);
      cnt <= cnt - 15'h0001;
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] x);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rd_data, x);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // high cycles of pair 1 over a window
  task automatic hcount(input int w, input logic [15:0] x);
    logic [15:0] k;
    k = 16'h0000;
    repeat (w) begin
      @(posedge clk);
      #1 k = k + {15'h0000, hi[0]};
    end
    chk(k, x);
  endtask
  // cycles from one pin of pair 1 dropping to the other rising
  task automatic gap(input logic up, input logic [15:0] x);
    logic [15:0] k;
    k = 16'h0000;
    while ((up ? lo[0] : hi[0]) && k < 16'h0032) begin
      @(posedge clk);
      #1 k++;
    end
    k = 16'h0000;
    while (!(up ? hi[0] : lo[0]) && k < 16'h00c8) begin
      @(posedge clk);
      #1 k++;
    end
    chk(k, x);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(i[3:0], 16'h0000);
    rdc(4'ha, 16'h0000);
    rdc(4'h9, 16'h0000);
    chk({8'h00, lo, hi}, 16'h00f0);
    e = 4'h0;
    for (int i = 0; i < 4; i++) begin
      wr(i[3:0], 16'h0008);
      rdc(i[3:0], 16'h0008);
      e = {e[2:0], 1'b1};
      settle();
      chk({8'h00, lo, hi}, {8'h00, ~e, e});
    end
    chk({12'h000, phase}, 16'h000f);
    $display("test pairs done");
    wr(4'h5, 16'h0001);
    wr(4'h0, 16'h0000);
    settle();
    chk({15'h0000, hi[0]}, 16'h0001);
    wr(4'h5, 16'h0003);
    wr(4'h0, 16'h0000);
    settle();
    chk({15'h0000, hi[0]}, 16'h0000);
    wr(4'h5, 16'h0000);
    $display("test lockout done");
    // every mode, empty and full duty
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 2; f++) begin
        run <= 1'b0;
        mode <= m[1:0];
        wr(4'h0, f ? 16'h0014 : 16'h0000);
        settle();
        run <= 1'b1;
        repeat (40) @(posedge clk);
        hcount(20, f ? 16'h0014 : 16'h0000);
      end
    end
    // center pulse: set on the down match, cleared on the up match
    mode <= 2'h2;
    wr(4'h0, 16'h0008);
    repeat (40) @(posedge clk);
    hcount(18, 16'h0008);
    mode <= 2'h0;
    wr(4'h0, 16'h0007);
    repeat (30) @(posedge clk);
    hcount(10, 16'h0004);
    wr(4'h0, 16'h0006);
    repeat (30) @(posedge clk);
    hcount(10, 16'h0003);
    $display("test modes done");
    run <= 1'b0;
    wr(4'h0, 16'h0000);
    // dead-time settings change only while stopped
    wr(4'h6, 16'h0503);
    wr(4'h7, 16'h0002);
    settle();
    wr(4'h0, 16'h0008);
    gap(1'b1, 16'h0003);
    wr(4'h0, 16'h0000);
    gap(1'b0, 16'h0005);
    wr(4'h7, 16'h0001);
    wr(4'h0, 16'h0008);
    gap(1'b1, 16'h0005);
    wr(4'h0, 16'h0000);
    gap(1'b0, 16'h0003);
    for (int j = 0; j < 4; j++) begin
      wr(4'h6, {j[1:0], 6'h02, j[1:0], 6'h02});
      wr(4'h0, 16'h0008);
      gap(1'b1, 16'h0002 << j);
      wr(4'h0, 16'h0000);
      gap(1'b0, 16'h0002 << j);
    end
    chk({8'h00, shoot}, 16'h0000);
    $display("test dead time done");
    wr(4'h6, 16'h0000);
    wr(4'h0, 16'h0008);
    wr(4'h8, 16'h0001);
    settle();
    chk({14'h0000, lo[0], hi[0]}, 16'h0000);
    wr(4'h8, 16'h0202);
    settle();
    chk({14'h0000, lo[0], hi[0]}, 16'h0003);
    wr(4'h8, 16'h0000);
    wr(4'h4, 16'h0001);
    settle();
    chk({14'h0000, lo[0], hi[0]}, 16'h0003);
    wr(4'h0, 16'h0000);
    settle();
    chk({14'h0000, lo[0], hi[0]}, 16'h0000);
    $display("test output modes done");
    end_sim();
  end
endmodule
`default_nettype wire
